// ==== shared/cpu_core_pkg.sv ====
// Constants and types shared by the CPU core register set and addressing.
// Assumes a combinational program memory and data memory read port.
package cpu_core_pkg;
  localparam logic [7:0] FLAGS_ADDR = 8'hF7;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] FLAGS_WR_MASK = 8'h17;
  localparam logic [7:0] REGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int GIE_BIT = 0;
  localparam int ZERO_BIT = 1;
  localparam int CARRY_BIT = 2;
  localparam int SUPER_BIT = 3;
  localparam int BANK_BIT = 4;
  localparam logic [7:0] OP_PUSH_A = 8'h08;
  localparam logic [7:0] OP_PUSH_X = 8'h10;
  localparam logic [7:0] OP_POP_A = 8'h18;
  localparam logic [7:0] OP_POP_X = 8'h20;
  localparam logic [7:0] OP_NOP = 8'h40;
  localparam logic [7:0] OP_ALU_END = 8'h38;
  localparam logic [7:0] OP_ADD_SP_IMM = 8'h38;
  localparam logic [7:0] OP_CMP_IMM = 8'h39;
  localparam logic [7:0] OP_CMP_DIR = 8'h3A;
  localparam logic [7:0] OP_CMP_IDX = 8'h3B;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h50;
  localparam logic [7:0] OP_MOV_A_DIR = 8'h51;
  localparam logic [7:0] OP_MOV_A_IDX = 8'h52;
  localparam logic [7:0] OP_MOV_DIR_A = 8'h53;
  localparam logic [7:0] OP_MOV_X_IMM = 8'h57;
  localparam logic [7:0] OP_MOV_X_DIR = 8'h58;
  localparam logic [7:0] OP_MOV_X_IDX = 8'h59;
  localparam logic [7:0] OP_MOV_DIR_X = 8'h5A;
  localparam logic [7:0] OP_MOV_A_REG = 8'h5D;
  localparam logic [7:0] OP_MOV_A_REGX = 8'h5E;
  localparam logic [7:0] OP_MOV_REG_A = 8'h60;
  localparam logic [7:0] OP_MOV_REGX_A = 8'h61;
  localparam logic [7:0] OP_AND_F_IMM = 8'h70;
  localparam logic [7:0] OP_OR_F_IMM = 8'h71;
  localparam logic [2:0] MODE_IMM = 3'h1;
  localparam logic [2:0] MODE_DIR = 3'h2;
  localparam logic [2:0] MODE_IDX = 3'h3;
  localparam logic [2:0] MODE_DST = 3'h4;

  typedef enum logic [1:0] {ST_OPCODE, ST_OPERAND, ST_READ} state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic reg_space;
    logic bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic [7:0] value;
  } alu_res_t;
endpackage

// ==== core/cpu_core_regs.sv ====
// CPU core register set, flags and operand addressing for two-byte modes.
// Assumes program and data memories answer combinationally to the address.
module cpu_core_regs (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_pm_data,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_supervisor,
  output logic [15:0] o_pm_addr,
  output logic [7:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic o_mem_reg,
  output logic o_mem_bank,
  output logic [7:0] o_flags,
  output logic [7:0] o_acc,
  output logic [7:0] o_index,
  output logic [7:0] o_sp,
  output logic o_global_irq_enable
);
  cpu_core_pkg::state_t state_ff, nxt_state;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] opc_ff, nxt_opc;
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] index_ff, nxt_index;
  logic [7:0] sp_ff, nxt_sp;
  logic [7:0] flags_ff, nxt_flags;
  cpu_core_pkg::mem_req_t mem_ff, nxt_mem;
  cpu_core_pkg::alu_res_t res;
  logic [7:0] src;
  logic [7:0] ea;

  // Operand fetch from data or register space; stores without a read are excluded.
  function automatic logic needs_read(input logic [7:0] op);
    logic mode_read;
    mode_read = (op[2:0] == cpu_core_pkg::MODE_DIR) ||
                (op[2:0] == cpu_core_pkg::MODE_IDX) ||
                (op[2:0] == cpu_core_pkg::MODE_DST);
    needs_read = ((op < cpu_core_pkg::OP_ALU_END) && mode_read) ||
                 (op == cpu_core_pkg::OP_CMP_DIR) ||
                 (op == cpu_core_pkg::OP_CMP_IDX) ||
                 (op == cpu_core_pkg::OP_MOV_A_DIR) ||
                 (op == cpu_core_pkg::OP_MOV_A_IDX) ||
                 (op == cpu_core_pkg::OP_MOV_X_DIR) ||
                 (op == cpu_core_pkg::OP_MOV_X_IDX) ||
                 (op == cpu_core_pkg::OP_MOV_A_REG) ||
                 (op == cpu_core_pkg::OP_MOV_A_REGX);
  endfunction

  function automatic logic is_indexed(input logic [7:0] op);
    is_indexed = ((op < cpu_core_pkg::OP_ALU_END) &&
                  (op[2:0] == cpu_core_pkg::MODE_IDX)) ||
                 (op == cpu_core_pkg::OP_CMP_IDX) ||
                 (op == cpu_core_pkg::OP_MOV_A_IDX) ||
                 (op == cpu_core_pkg::OP_MOV_X_IDX) ||
                 (op == cpu_core_pkg::OP_MOV_A_REGX) ||
                 (op == cpu_core_pkg::OP_MOV_REGX_A);
  endfunction

  function automatic logic is_reg_space(input logic [7:0] op);
    is_reg_space = (op == cpu_core_pkg::OP_MOV_A_REG) ||
                   (op == cpu_core_pkg::OP_MOV_A_REGX) ||
                   (op == cpu_core_pkg::OP_MOV_REG_A) ||
                   (op == cpu_core_pkg::OP_MOV_REGX_A);
  endfunction

  // Logic operations pass carry through so only zero changes for them.
  function automatic cpu_core_pkg::alu_res_t alu(input logic [2:0] grp,
      input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    cpu_core_pkg::alu_res_t r;
    s = {1'b0, a};
    case (grp)
      3'h0: s = {1'b0, a} + {1'b0, b};
      3'h1: s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      3'h2: s = {1'b0, a} - {1'b0, b};
      3'h3: s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      3'h4: s = {cin, a & b};
      3'h5: s = {cin, a | b};
      3'h6: s = {cin, a ^ b};
      default: s = {cin, a};
    endcase
    r.carry = s[8];
    r.value = s[7:0];
    r.zero = (s[7:0] == 8'h00);
    alu = r;
  endfunction

  always_comb begin
    src = (state_ff == cpu_core_pkg::ST_READ) ? i_mem_rdata : i_pm_data;
    if (state_ff == cpu_core_pkg::ST_READ && mem_ff.reg_space &&
        mem_ff.addr == cpu_core_pkg::FLAGS_ADDR) begin
      src = flags_ff;
    end
    ea = is_indexed(opc_ff) ? i_pm_data + index_ff : i_pm_data;
    // Destination forms take the stored byte first, so subtraction is
    // memory minus accumulator as the operand order demands.
    if (opc_ff[2:0] == cpu_core_pkg::MODE_DST) begin
      res = alu(opc_ff[5:3], src, acc_ff, flags_ff[cpu_core_pkg::CARRY_BIT]);
    end else begin
      res = alu(opc_ff[5:3], acc_ff, src, flags_ff[cpu_core_pkg::CARRY_BIT]);
    end
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_opc = opc_ff;
    nxt_acc = acc_ff;
    nxt_index = index_ff;
    nxt_sp = sp_ff;
    nxt_flags = flags_ff;
    nxt_mem = '0;
    nxt_mem.bank = flags_ff[cpu_core_pkg::BANK_BIT];
    case (state_ff)
      cpu_core_pkg::ST_OPCODE: begin
        nxt_opc = i_pm_data;
        nxt_pc = pc_ff + 16'h0001;
        nxt_state = cpu_core_pkg::ST_OPERAND;
        if (i_pm_data == cpu_core_pkg::OP_PUSH_A ||
            i_pm_data == cpu_core_pkg::OP_PUSH_X) begin
          nxt_state = cpu_core_pkg::ST_OPCODE;
          nxt_mem.wr = 1'b1;
          nxt_mem.addr = sp_ff;
          nxt_mem.wdata = (i_pm_data == cpu_core_pkg::OP_PUSH_A) ?
                          acc_ff : index_ff;
          nxt_sp = sp_ff + 8'h01;
        end else if (i_pm_data == cpu_core_pkg::OP_POP_A ||
                     i_pm_data == cpu_core_pkg::OP_POP_X) begin
          nxt_state = cpu_core_pkg::ST_READ;
          nxt_mem.rd = 1'b1;
          nxt_mem.addr = sp_ff - 8'h01;
          nxt_sp = sp_ff - 8'h01;
        end else if (i_pm_data == cpu_core_pkg::OP_NOP) begin
          nxt_state = cpu_core_pkg::ST_OPCODE;
        end
      end
      cpu_core_pkg::ST_OPERAND: begin
        nxt_pc = pc_ff + 16'h0001;
        nxt_state = cpu_core_pkg::ST_OPCODE;
        if (needs_read(opc_ff)) begin
          nxt_state = cpu_core_pkg::ST_READ;
          nxt_mem.rd = 1'b1;
          nxt_mem.addr = ea;
          nxt_mem.reg_space = is_reg_space(opc_ff);
        end else if (opc_ff < cpu_core_pkg::OP_ALU_END &&
                     opc_ff[2:0] == cpu_core_pkg::MODE_IMM) begin
          nxt_acc = res.value;
          nxt_flags[cpu_core_pkg::ZERO_BIT] = res.zero;
          nxt_flags[cpu_core_pkg::CARRY_BIT] = res.carry;
        end else begin
          case (opc_ff)
            cpu_core_pkg::OP_CMP_IMM: begin
              nxt_flags[cpu_core_pkg::ZERO_BIT] = (acc_ff == i_pm_data);
              nxt_flags[cpu_core_pkg::CARRY_BIT] = (acc_ff < i_pm_data);
            end
            cpu_core_pkg::OP_ADD_SP_IMM: nxt_sp = sp_ff + i_pm_data;
            cpu_core_pkg::OP_MOV_A_IMM: begin
              nxt_acc = i_pm_data;
              nxt_flags[cpu_core_pkg::ZERO_BIT] = (i_pm_data == 8'h00);
            end
            cpu_core_pkg::OP_MOV_X_IMM: nxt_index = i_pm_data;
            cpu_core_pkg::OP_AND_F_IMM: begin
              nxt_flags = flags_ff &
                          (i_pm_data | ~cpu_core_pkg::FLAGS_WR_MASK);
            end
            cpu_core_pkg::OP_OR_F_IMM: begin
              nxt_flags = flags_ff |
                          (i_pm_data & cpu_core_pkg::FLAGS_WR_MASK);
            end
            cpu_core_pkg::OP_MOV_DIR_A, cpu_core_pkg::OP_MOV_DIR_X,
            cpu_core_pkg::OP_MOV_REG_A, cpu_core_pkg::OP_MOV_REGX_A: begin
              nxt_mem.wr = 1'b1;
              nxt_mem.addr = ea;
              nxt_mem.reg_space = is_reg_space(opc_ff);
              nxt_mem.wdata = (opc_ff == cpu_core_pkg::OP_MOV_DIR_X) ?
                              index_ff : acc_ff;
            end
            default: nxt_state = cpu_core_pkg::ST_OPCODE;
          endcase
        end
      end
      cpu_core_pkg::ST_READ: begin
        nxt_state = cpu_core_pkg::ST_OPCODE;
        if ((opc_ff < cpu_core_pkg::OP_ALU_END &&
             opc_ff > cpu_core_pkg::OP_POP_X) ||
            (opc_ff < cpu_core_pkg::OP_ALU_END &&
                opc_ff[2:0] != cpu_core_pkg::MODE_IMM &&
                opc_ff[2:0] != 3'h0)) begin
          nxt_flags[cpu_core_pkg::ZERO_BIT] = res.zero;
          nxt_flags[cpu_core_pkg::CARRY_BIT] = res.carry;
          if (opc_ff[2:0] == cpu_core_pkg::MODE_DST) begin
            nxt_mem.wr = 1'b1;
            nxt_mem.addr = mem_ff.addr;
            nxt_mem.wdata = res.value;
          end else begin
            nxt_acc = res.value;
          end
        end else begin
          case (opc_ff)
            cpu_core_pkg::OP_CMP_DIR, cpu_core_pkg::OP_CMP_IDX: begin
              nxt_flags[cpu_core_pkg::ZERO_BIT] = (acc_ff == src);
              nxt_flags[cpu_core_pkg::CARRY_BIT] = (acc_ff < src);
            end
            cpu_core_pkg::OP_MOV_A_DIR, cpu_core_pkg::OP_MOV_A_IDX,
            cpu_core_pkg::OP_MOV_A_REG, cpu_core_pkg::OP_MOV_A_REGX,
            cpu_core_pkg::OP_POP_A: begin
              nxt_acc = src;
              nxt_flags[cpu_core_pkg::ZERO_BIT] = (src == 8'h00);
            end
            cpu_core_pkg::OP_MOV_X_DIR, cpu_core_pkg::OP_MOV_X_IDX,
            cpu_core_pkg::OP_POP_X: nxt_index = src;
            default: nxt_index = index_ff;
          endcase
        end
      end
      default: nxt_state = cpu_core_pkg::ST_OPCODE;
    endcase
  end

  // Program fetch and data access use separate ports.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= cpu_core_pkg::ST_OPCODE;
      pc_ff <= cpu_core_pkg::PC_RESET;
      opc_ff <= cpu_core_pkg::REGS_RESET;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      opc_ff <= nxt_opc;
    end
  end

  // Core registers have no address decode, so stores cannot reach them.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_ff <= cpu_core_pkg::REGS_RESET;
      index_ff <= cpu_core_pkg::REGS_RESET;
      sp_ff <= cpu_core_pkg::REGS_RESET;
    end else begin
      acc_ff <= nxt_acc;
      index_ff <= nxt_index;
      sp_ff <= nxt_sp;
    end
  end

  // Supervisor state follows the core mode input, not any write.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flags_ff <= cpu_core_pkg::FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags & cpu_core_pkg::FLAGS_WR_MASK;
      flags_ff[cpu_core_pkg::SUPER_BIT] <= i_supervisor;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mem_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
    end
  end

  assign o_pm_addr = pc_ff;
  assign o_mem_addr = mem_ff.addr;
  assign o_mem_wdata = mem_ff.wdata;
  assign o_mem_rd = mem_ff.rd;
  assign o_mem_wr = mem_ff.wr;
  assign o_mem_reg = mem_ff.reg_space;
  assign o_mem_bank = mem_ff.bank;
  assign o_flags = flags_ff;
  assign o_acc = acc_ff;
  assign o_index = index_ff;
  assign o_sp = sp_ff;
  assign o_global_irq_enable = flags_ff[cpu_core_pkg::GIE_BIT];

  a_operand_pc_step: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_OPERAND |=>
      pc_ff == $past(pc_ff) + 16'h0001 &&
      state_ff != cpu_core_pkg::ST_OPERAND)
    else $error("Operand byte did not advance the counter by one.");
  a_flags_reserved: assert property (
    @(posedge i_clk) disable iff (i_reset)
    flags_ff[7:5] == 3'h0)
    else $error("Reserved flag bits are not zero.");
  a_super_tracks: assert property (
    @(posedge i_clk) disable iff (i_reset)
    1'b1 |=> flags_ff[cpu_core_pkg::SUPER_BIT] == $past(i_supervisor))
    else $error("Supervisor bit does not follow core mode.");
  a_store_keeps_flags: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_OPERAND &&
    opc_ff == cpu_core_pkg::OP_MOV_REG_A |=>
      (flags_ff & cpu_core_pkg::FLAGS_WR_MASK) ==
      ($past(flags_ff) & cpu_core_pkg::FLAGS_WR_MASK))
    else $error("Register-space store changed the flags.");
  a_imm_add_acc: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_OPERAND && opc_ff == 8'h01 |=>
      acc_ff == 8'($past(acc_ff) + $past(i_pm_data)))
    else $error("Immediate add result missing from accumulator.");
  a_indexed_addr: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_OPERAND && opc_ff == 8'h03 |=>
      o_mem_rd && o_mem_addr == 8'($past(i_pm_data) + $past(index_ff)))
    else $error("Indexed source address is not operand plus index.");
  a_direct_addr: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_OPERAND && opc_ff == 8'h02 |=>
      o_mem_rd && !o_mem_reg && o_mem_addr == $past(i_pm_data))
    else $error("Direct source address is not the operand.");
  a_dest_write: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_READ && opc_ff == 8'h04 |=>
      o_mem_wr && o_mem_addr == $past(o_mem_addr) && acc_ff == $past(acc_ff))
    else $error("Destination write missing or accumulator disturbed.");
  a_push_sp: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_OPCODE && i_pm_data == 8'h08 |=>
      o_mem_wr && sp_ff == 8'($past(sp_ff) + 8'h01))
    else $error("Push did not store and raise the stack pointer.");
  a_bank_select: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_mem_rd |-> o_mem_bank == $past(flags_ff[cpu_core_pkg::BANK_BIT]))
    else $error("Bank output does not match the bank flag.");
  a_flags_readback: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_ff == cpu_core_pkg::ST_READ && opc_ff == 8'h5D &&
    o_mem_addr == 8'hF7 |=> acc_ff == $past(flags_ff))
    else $error("Flags address read did not return the flags.");
endmodule

// ==== dv/cpu_core_mem_model.sv ====
// Program memory and data memory that sit opposite the CPU core block.
// Assumes one request per cycle, launched on the rising edge of i_clk.
module cpu_core_mem_model (
  input wire logic i_clk,
  input wire logic [15:0] i_pm_addr,
  output logic [7:0] o_pm_data,
  input wire cpu_core_pkg::mem_req_t i_req,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pm [0:8191];
  logic [7:0] ram [0:255];
  logic [7:0] regs [0:1][0:255];
  logic [7:0] last_ff = 8'h00;
  // Program bytes arrive on a port of their own, apart from data.
  assign o_pm_data = pm[i_pm_addr[12:0]];
  // An idle read port shows the inverse of its last byte, never a stale copy.
  always_comb begin
    if (!i_req.rd)
      o_rdata = ~last_ff;
    else if (i_req.reg_space)
      o_rdata = regs[i_req.bank][i_req.addr];
    else
      o_rdata = ram[i_req.addr];
  end
  always @(posedge i_clk) begin
    last_ff <= o_rdata;
    if (i_req.wr && i_req.reg_space)
      regs[i_req.bank][i_req.addr] <= i_req.wdata;
    else if (i_req.wr)
      ram[i_req.addr] <= i_req.wdata;
  end
endmodule

// ==== dv/cpu_core_regs_tb.sv ====
// Self-checking bench for the CPU core register set and addressing.
// Assumes the memory model answers reads within the request cycle.
module cpu_core_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk;
  logic i_reset;
  logic i_supervisor;
  logic [7:0] pm_data, rdata, mem_addr, mem_wdata, flags, acc, index, sp;
  logic [15:0] pm_addr;
  logic mem_rd, mem_wr, mem_reg, mem_bank, gie;
  cpu_core_pkg::mem_req_t req;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  assign req = {mem_rd, mem_wr, mem_reg, mem_bank, mem_addr, mem_wdata};
  cpu_core_regs dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_pm_data(pm_data),
    .i_mem_rdata(rdata), .i_supervisor(i_supervisor),
    .o_pm_addr(pm_addr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_reg(mem_reg),
    .o_mem_bank(mem_bank), .o_flags(flags), .o_acc(acc),
    .o_index(index), .o_sp(sp), .o_global_irq_enable(gie)
  );
  cpu_core_mem_model mdl (
    .i_clk(i_clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data),
    .i_req(req), .o_rdata(rdata)
  );
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The whole run needs some 315 cycles; far beyond that means a hang.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Holds reset for 12 cycles while the program is loaded, NOP padded.
  task automatic start(input logic [7:0] prog[$], input logic sup);
    @(posedge i_clk);
    #1;
    i_reset = 1'b1;
    i_supervisor = sup;
    for (int i = 0; i < 8192; i++)
      mdl.pm[i] = (i < prog.size()) ? prog[i] : cpu_core_pkg::OP_NOP;
    repeat (12) @(posedge i_clk);
    #1;
  endtask
  // Releases reset and lets the program finish inside the NOP padding.
  task automatic go_run();
    i_reset = 1'b0;
    repeat (60) @(posedge i_clk);
    #1;
  endtask
  task automatic t_reset();
    start('{8'h40}, 1'b0);
    chk("flags", {8'h00, 8'h02}, {8'h00, flags});
    chk("acc", 16'h0000, {8'h00, acc});
    chk("index", 16'h0000, {8'h00, index});
    chk("sp", 16'h0000, {8'h00, sp});
    chk("pc", 16'h0000, pm_addr);
    i_reset = 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    chk("pc", 16'h000A, pm_addr);
  endtask
  task automatic t_imm();
    start('{8'h01, 8'hFF, 8'h01, 8'h01, 8'h57, 8'h05, 8'h38, 8'h03,
            8'h71, 8'h01}, 1'b0);
    go_run();
    chk("acc", 16'h0000, {8'h00, acc});
    chk("flags", 16'h0007, {8'h00, flags});
    chk("index", 16'h0005, {8'h00, index});
    chk("sp", 16'h0003, {8'h00, sp});
    chk("gie", 16'h0001, {15'h0000, gie});
  endtask
  task automatic t_dir();
    start('{8'h57, 8'h05, 8'h51, 8'h10, 8'h03, 8'h10, 8'h04, 8'h10,
            8'h5A, 8'h20, 8'h02, 8'h30}, 1'b0);
    mdl.ram[8'h30] = 8'h00;
    mdl.ram[8'h10] = 8'h33;
    mdl.ram[8'h15] = 8'h44;
    mdl.ram[8'h20] = 8'hFF;
    go_run();
    chk("acc", 16'h0077, {8'h00, acc});
    chk("ram_10", 16'h00AA, {8'h00, mdl.ram[8'h10]});
    chk("ram_20", 16'h0005, {8'h00, mdl.ram[8'h20]});
    chk("flags", 16'h0000, {8'h00, flags});
  endtask
  // Supervisor level stays high so code can neither set nor clear bit 3.
  task automatic t_flags();
    start('{8'h50, 8'h00, 8'h71, 8'hFF, 8'h60, 8'hF7, 8'h5D, 8'hF7,
            8'h60, 8'h30, 8'h70, 8'h00, 8'h50, 8'h00, 8'h60, 8'h30}, 1'b1);
    mdl.regs[0][8'h30] = 8'hFF;
    mdl.regs[1][8'h30] = 8'h00;
    go_run();
    chk("bank1_30", 16'h001F, {8'h00, mdl.regs[1][8'h30]});
    chk("bank0_30", 16'h0000, {8'h00, mdl.regs[0][8'h30]});
    chk("flags", 16'h000A, {8'h00, flags});
    chk("gie", 16'h0000, {15'h0000, gie});
    chk("acc", 16'h0000, {8'h00, acc});
  endtask
  task automatic t_stack();
    start('{8'h57, 8'h33, 8'h10, 8'h50, 8'h5A, 8'h08, 8'h50, 8'h00,
            8'h18, 8'h57, 8'h00, 8'h20}, 1'b0);
    mdl.ram[8'h00] = 8'hFF;
    mdl.ram[8'h01] = 8'hFF;
    go_run();
    chk("ram_00", 16'h0033, {8'h00, mdl.ram[8'h00]});
    chk("ram_01", 16'h005A, {8'h00, mdl.ram[8'h01]});
    chk("index", 16'h0033, {8'h00, index});
    chk("sp", 16'h0000, {8'h00, sp});
    chk("acc", 16'h005A, {8'h00, acc});
    chk("flags", 16'h0000, {8'h00, flags});
  endtask
  initial begin
    i_reset = 1'b1;
    i_supervisor = 1'b0;
    t_reset();
    t_imm();
    t_dir();
    t_flags();
    t_stack();
    report_and_stop();
  end
endmodule
